// ==== ptd_config_bank.sv ====
// Protection threshold and delay configuration bank with its fault sequencer
// Contract
// - Undervoltage trip is 1.4 V plus 100 mV per code, up to 2.9 V.
// - Hysteresis code selects 0.2, 0.4, 0.8 or 1.2 V.
// - Undervoltage releases at trip plus hysteresis, capped at 3.3 V.
// - In host mode, FET-disable bit set keeps discharge drive on at undervoltage.
// - Undervoltage detected from idle sets the status flag at offset zero unless overcurrent expires in the same cycle.
// - Overcurrent trip is 10 mV plus 5 mV per code, up to 85 mV.
// - Undervoltage delay is (code mod 8)+1 seconds, codes 8 to 15 give 1 to 8 s.
// - Fast scale gives internal counts 0..24, each count lasting cellCount base ticks.
// - Overcurrent delay is 20 ms steps for codes 0-15, 100 ms steps above.
// - Stand-alone, recovery-select clear: recover with charger after 12.8 s.
// - Stand-alone, recovery-select set: recover when fault clears after 12.8 s.
// - Precharge open-drain drive only in stand-alone with zero-volt bit set.
// - Cell balancing runs only when the balancing-enable bit is set.
`timescale 1ns/10ps
module ptd_config_bank #(
  parameter int TickCycles = ptd_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input ptd_pkg::ptd_regreq_s regReq,
  output logic [7:0] regRdData,
  input ptd_pkg::ptd_meas_s meas,
  input wire logic hostMode,
  input wire logic chargerPresent,
  input wire logic fastDelayScale,
  input wire logic [3:0] cellCount,
  input wire logic balanceRequest,
  output logic dischargeFetDrive,
  output logic prechargeOpenDrainOut,
  output logic prechargeOpenDrainOe,
  output logic balancingActive
);
  ptd_pkg::ptd_state_s st_r;
  ptd_pkg::ptd_state_s st_nxt;
  logic [3:0] uvCode;
  logic [3:0] uvDelayCode;
  logic [4:0] ocDelayCode;
  logic [1:0] hystCode;
  logic [11:0] uvTripMv;
  logic [11:0] hystMv;
  logic [12:0] releaseSum;
  logic [11:0] releaseMv;
  logic [7:0] ocTripMv;
  logic [ptd_pkg::TMR_W-1:0] uvTarget;
  logic [ptd_pkg::TMR_W-1:0] ocTarget;
  logic uvRun;
  logic ocRun;
  logic recRun;
  logic uvDone;
  logic ocDone;
  logic recDone;
  logic ocRecover;

  assign uvCode = st_r.undervoltageConfig[ptd_pkg::UV_TRIP_LSB +: 4];
  assign hystCode = st_r.undervoltageConfig[ptd_pkg::UV_HYST_LSB +: 2];
  assign uvDelayCode = st_r.overcurrentUndervoltageDelay[ptd_pkg::UV_DELAY_LSB +: 4];
  assign ocDelayCode = st_r.dischargeOvercurrentConfig[ptd_pkg::OC_DELAY_LSB +: 5];

  assign uvTripMv = ptd_pkg::UV_TRIP_BASE_MV + 12'(uvCode * ptd_pkg::UV_TRIP_STEP_MV);
  assign hystMv = ptd_pkg::UV_HYST_MV[hystCode];
  assign releaseSum = {1'b0, uvTripMv} + {1'b0, hystMv};
  // Cap keeps the release reachable whatever pair software picks
  assign releaseMv = (releaseSum > {1'b0, ptd_pkg::UV_RELEASE_CAP_MV}) ? ptd_pkg::UV_RELEASE_CAP_MV
                     : releaseSum[11:0];
  assign ocTripMv = ptd_pkg::OC_TRIP_BASE_MV
                    + 8'(st_r.overcurrentUndervoltageDelay[ptd_pkg::OC_TRIP_LSB +: 4]
                    * ptd_pkg::OC_TRIP_STEP_MV);

  always_comb
  begin
    if (fastDelayScale && !uvDelayCode[3])
    begin
      uvTarget = ptd_pkg::TMR_W'(ptd_pkg::FAST_COUNT[uvDelayCode[2:0]]) * ptd_pkg::TMR_W'(cellCount);
    end
    else
    begin
      uvTarget = ptd_pkg::TMR_W'((int'(uvDelayCode[2:0]) + 1)
                 * ptd_pkg::UV_DELAY_STEP_MS * ptd_pkg::TICKS_PER_MS);
    end
    if (!ocDelayCode[4])
    begin
      ocTarget = ptd_pkg::TMR_W'((int'(ocDelayCode[3:0]) + 1)
                 * ptd_pkg::OC_SHORT_STEP_MS * ptd_pkg::TICKS_PER_MS);
    end
    else
    begin
      ocTarget = ptd_pkg::TMR_W'((int'(ocDelayCode[3:0]) + 1)
                 * ptd_pkg::OC_LONG_STEP_MS * ptd_pkg::TICKS_PER_MS);
    end
  end

  assign uvRun = (st_r.prot == ptd_pkg::PROT_IDLE) && (meas.cellMinMv < uvTripMv);
  assign ocRun = (st_r.prot == ptd_pkg::PROT_IDLE) && (meas.senseMv >= ocTripMv);
  assign recRun = (st_r.prot == ptd_pkg::PROT_OC);

  ptd_delay_timer uUvTimer (
    .clk(clk),
    .arst_n(arst_n),
    .run(uvRun),
    .tick(st_r.tick),
    .target(uvTarget),
    .expired(uvDone)
  );

  ptd_delay_timer uOcTimer (
    .clk(clk),
    .arst_n(arst_n),
    .run(ocRun),
    .tick(st_r.tick),
    .target(ocTarget),
    .expired(ocDone)
  );

  // Recovery window restarts at each detection
  ptd_delay_timer uRecTimer (
    .clk(clk),
    .arst_n(arst_n),
    .run(recRun),
    .tick(st_r.tick),
    .target(ptd_pkg::TMR_W'(ptd_pkg::RECOVERY_TICKS)),
    .expired(recDone)
  );

  always_comb
  begin
    if (hostMode)
    begin
      // Host decides by clearing the overcurrent flag
      ocRecover = !st_r.ocFlag;
    end
    else if (st_r.dischargeOvercurrentConfig[ptd_pkg::SOR_BIT])
    begin
      ocRecover = recDone && (meas.senseMv < ocTripMv);
    end
    else
    begin
      ocRecover = recDone && chargerPresent;
    end
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.tickCnt >= ptd_pkg::TICK_W'(TickCycles - 1))
    begin
      st_nxt.tickCnt = '0;
      st_nxt.tick = 1'b1;
    end
    else
    begin
      st_nxt.tickCnt = st_r.tickCnt + 1'b1;
    end
    if (regReq.wrEn)
    begin
      unique case (regReq.addr)
        ptd_pkg::ADDR_STATUS:
        begin
          // Write one to clear; a same-cycle detection below wins
          st_nxt.uvFlag = st_r.uvFlag & ~regReq.data[ptd_pkg::STAT_UV_BIT];
          st_nxt.ocFlag = st_r.ocFlag & ~regReq.data[ptd_pkg::STAT_OC_BIT];
        end
        ptd_pkg::ADDR_UNDERVOLTAGE_CONFIG: st_nxt.undervoltageConfig = regReq.data;
        ptd_pkg::ADDR_DELAY: st_nxt.overcurrentUndervoltageDelay = regReq.data;
        ptd_pkg::ADDR_DISCHARGE_OVERCURRENT_CONFIG: st_nxt.dischargeOvercurrentConfig = regReq.data;
        default: st_nxt.tick = st_nxt.tick;
      endcase
    end
    unique case (regReq.addr)
      ptd_pkg::ADDR_STATUS: st_nxt.rdData = {6'h00, st_r.ocFlag, st_r.uvFlag};
      ptd_pkg::ADDR_UNDERVOLTAGE_CONFIG: st_nxt.rdData = st_r.undervoltageConfig;
      ptd_pkg::ADDR_DELAY: st_nxt.rdData = st_r.overcurrentUndervoltageDelay;
      ptd_pkg::ADDR_DISCHARGE_OVERCURRENT_CONFIG: st_nxt.rdData = st_r.dischargeOvercurrentConfig;
      default: st_nxt.rdData = 8'h00;
    endcase
    unique case (st_r.prot)
      ptd_pkg::PROT_IDLE:
      begin
        // Overcurrent outranks undervoltage when both expire together
        if (ocDone)
        begin
          st_nxt.prot = ptd_pkg::PROT_OC;
          st_nxt.ocFlag = 1'b1;
        end
        else if (uvDone)
        begin
          st_nxt.prot = ptd_pkg::PROT_UV;
          st_nxt.uvFlag = 1'b1;
          st_nxt.uvDropsFet = !(hostMode && st_r.undervoltageConfig[ptd_pkg::UV_FETDIS_BIT]);
        end
      end
      ptd_pkg::PROT_UV:
      begin
        if (meas.cellMinMv >= releaseMv)
        begin
          st_nxt.prot = ptd_pkg::PROT_IDLE;
        end
      end
      ptd_pkg::PROT_OC:
      begin
        if (ocRecover)
        begin
          st_nxt.prot = ptd_pkg::PROT_IDLE;
        end
      end
      default:
      begin
        st_nxt.prot = ptd_pkg::PROT_IDLE;
      end
    endcase
    st_nxt.discharge_fet_drive = !((st_nxt.prot == ptd_pkg::PROT_OC)
                 || ((st_nxt.prot == ptd_pkg::PROT_UV) && st_nxt.uvDropsFet));
    st_nxt.precharge = !hostMode && st_r.dischargeOvercurrentConfig[ptd_pkg::ZVC_BIT]
                       && chargerPresent && (meas.cellMinMv < uvTripMv);
    st_nxt.balance = st_r.dischargeOvercurrentConfig[ptd_pkg::BALANCING_ENABLE_BIT] && balanceRequest;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= '0;
      st_r.undervoltageConfig <= ptd_pkg::RST_UNDERVOLTAGE_CONFIG;
      st_r.overcurrentUndervoltageDelay <= ptd_pkg::RST_DELAY;
      st_r.dischargeOvercurrentConfig <= ptd_pkg::RST_DISCHARGE_OVERCURRENT_CONFIG;
      st_r.prot <= ptd_pkg::PROT_IDLE;
      st_r.discharge_fet_drive <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign regRdData = st_r.rdData;
  assign dischargeFetDrive = st_r.discharge_fet_drive;
  // Open drain only ever pulls low
  assign prechargeOpenDrainOut = 1'b0;
  assign prechargeOpenDrainOe = st_r.precharge;
  assign balancingActive = st_r.balance;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_uv_detect;
    (st_r.prot == ptd_pkg::PROT_IDLE) && uvDone && !ocDone;
  endsequence

  a_trip_range: assert property ((uvCode == 4'hF) |-> (uvTripMv == 12'hB54))
    else $error("undervoltage trip code 15 not 2.9 V");
  a_hyst_decode: assert property ((hystCode == 2'h2) |-> (hystMv == 12'h320))
    else $error("hysteresis code 2 not 0.8 V");
  a_release_cap: assert property ((uvCode == 4'hF) && (hystCode == 2'h3) |-> (releaseMv == 12'hCE4))
    else $error("release level not capped at 3.3 V");
  a_uv_release: assert property ((st_r.prot == ptd_pkg::PROT_UV) && (meas.cellMinMv >= releaseMv)
    |=> (st_r.prot == ptd_pkg::PROT_IDLE) && dischargeFetDrive)
    else $error("undervoltage not released");
  a_uv_fet_drop: assert property (s_uv_detect and !(hostMode && st_r.undervoltageConfig[6])
    |=> !dischargeFetDrive)
    else $error("discharge drive stayed on at undervoltage");
  a_uv_fet_kept: assert property (s_uv_detect and (hostMode && st_r.undervoltageConfig[6])
    |=> dischargeFetDrive ##1 dischargeFetDrive)
    else $error("discharge drive changed with FET disable set");
  a_uv_flag_set: assert property (s_uv_detect |=> st_r.uvFlag && (st_r.prot == ptd_pkg::PROT_UV))
    else $error("undervoltage flag not set");
  a_oc_trip: assert property ((st_r.overcurrentUndervoltageDelay[3:0] == 4'hF) |-> (ocTripMv == 8'h55))
    else $error("overcurrent trip code 15 not 85 mV");
  a_uv_delay: assert property (!fastDelayScale && (uvDelayCode == 4'h0) |-> (uvTarget == 20'h01F40))
    else $error("undervoltage delay code 0 not 1 s");
  a_uv_fast: assert property (fastDelayScale && (uvDelayCode == 4'h7) && (cellCount == 4'h5)
    |-> (uvTarget == 20'h00078))
    else $error("fast delay count 24 at five cells wrong");
  a_oc_delay: assert property ((ocDelayCode == 5'h1F) |-> (ocTarget == 20'h03200))
    else $error("overcurrent delay code 31 not 1600 ms");
  a_sor_charger: assert property (!hostMode && !st_r.dischargeOvercurrentConfig[5]
    && (st_r.prot == ptd_pkg::PROT_OC) && !chargerPresent |=> (st_r.prot == ptd_pkg::PROT_OC))
    else $error("recovered without charger");
  a_sor_release: assert property (!hostMode && st_r.dischargeOvercurrentConfig[5] && recDone
    && (st_r.prot == ptd_pkg::PROT_OC) && (meas.senseMv < ocTripMv) |=> dischargeFetDrive)
    else $error("no recovery after fault cleared");
  a_zvc_gate: assert property (hostMode || !st_r.dischargeOvercurrentConfig[6] |=> !prechargeOpenDrainOe)
    else $error("precharge drive without zero-volt enable");
  a_balance_gate: assert property (!st_r.dischargeOvercurrentConfig[7] |=> !balancingActive)
    else $error("balancing without enable");
  a_balance_on: assert property (st_r.dischargeOvercurrentConfig[7] && balanceRequest |=> balancingActive)
    else $error("balancing enabled and requested but idle");
  a_oc_delay_short: assert property ((ocDelayCode == 5'h0F) |-> (ocTarget == 20'h00A00))
    else $error("overcurrent delay code 15 not 320 ms");
endmodule

// ==== ptd_delay_timer.sv ====
// Tick-based delay timer: expires once run has held for target ticks
`timescale 1ns/10ps
module ptd_delay_timer (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic tick,
  input wire logic [ptd_pkg::TMR_W-1:0] target,
  output logic expired
);
  ptd_pkg::ptd_tmr_s st_r;
  ptd_pkg::ptd_tmr_s st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (!run)
    begin
      // Dropping run restarts the delay from zero
      st_nxt.count = '0;
    end
    else if (tick && !st_r.expired)
    begin
      st_nxt.count = st_r.count + 1'b1;
    end
    st_nxt.expired = run && (st_nxt.count >= target);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign expired = st_r.expired;

  a_timer_restart: assert property (@(posedge clk) disable iff (!arst_n) !run |=> !expired)
    else $error("timer expired without run");
endmodule

// ==== ptd_host_model.sv ====
// Host model driving register requests over the management link
`timescale 1ns/10ps
module ptd_host_model (
  input wire logic clk,
  output ptd_pkg::ptd_regreq_s regReq
);
  initial regReq = '0;
  // Data lines toggle once released, so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regReq <= '{1'b1, a, (a == ptd_pkg::ADDR_UNDERVOLTAGE_CONFIG) ? (d & 8'h7F) : d};
    @(negedge clk);
    regReq.wrEn <= 1'b0;
    regReq.data <= ~regReq.data;
  endtask
  task automatic sel(input logic [7:0] a);
    @(negedge clk);
    regReq.addr <= a;
  endtask
endmodule

// ==== ptd_pkg.sv ====
// Constants, field layout and carrier types for the protection threshold and delay configuration block
package ptd_pkg;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_UNDERVOLTAGE_CONFIG = 8'h07;
  localparam logic [7:0] ADDR_DELAY = 8'h08;
  localparam logic [7:0] ADDR_DISCHARGE_OVERCURRENT_CONFIG = 8'h09;
  localparam logic [7:0] RST_UNDERVOLTAGE_CONFIG = 8'h00;
  localparam logic [7:0] RST_DELAY = 8'h00;
  localparam logic [7:0] RST_DISCHARGE_OVERCURRENT_CONFIG = 8'h00;

  // Field positions
  localparam int UV_TRIP_LSB = 0;
  localparam int UV_HYST_LSB = 4;
  localparam int UV_FETDIS_BIT = 6;
  localparam int OC_TRIP_LSB = 0;
  localparam int UV_DELAY_LSB = 4;
  localparam int OC_DELAY_LSB = 0;
  localparam int SOR_BIT = 5;
  localparam int ZVC_BIT = 6;
  localparam int BALANCING_ENABLE_BIT = 7;
  localparam int STAT_UV_BIT = 0;
  localparam int STAT_OC_BIT = 1;

  // Levels in millivolts
  localparam logic [11:0] UV_TRIP_BASE_MV = 12'h578;
  localparam logic [11:0] UV_TRIP_STEP_MV = 12'h064;
  localparam logic [11:0] UV_RELEASE_CAP_MV = 12'hCE4;
  localparam logic [11:0] UV_HYST_MV [4] = '{12'h0C8, 12'h190, 12'h320, 12'h4B0};
  localparam logic [7:0] OC_TRIP_BASE_MV = 8'h0A;
  localparam logic [7:0] OC_TRIP_STEP_MV = 8'h05;

  // Timing: one base tick is 125 us, fast-scale counts last cellCount base ticks
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS = 125000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICKS_PER_MS = 1000000 / TICK_NS;
  localparam int UV_DELAY_STEP_MS = 1000;
  localparam int OC_SHORT_STEP_MS = 20;
  localparam int OC_LONG_STEP_MS = 100;
  localparam int RECOVERY_MS = 12800;
  localparam int RECOVERY_TICKS = RECOVERY_MS * TICKS_PER_MS;
  localparam logic [4:0] FAST_COUNT [8] = '{5'h00, 5'h02, 5'h04, 5'h08, 5'h0A, 5'h0C, 5'h10, 5'h18};
  localparam int TICK_W = 12;
  localparam int TMR_W = 20;

  typedef enum logic [1:0] {PROT_IDLE, PROT_UV, PROT_OC} ptd_prot_e;

  typedef struct packed {
    logic wrEn;
    logic [7:0] addr;
    logic [7:0] data;
  } ptd_regreq_s;

  typedef struct packed {
    logic [11:0] cellMinMv;
    logic [7:0] senseMv;
  } ptd_meas_s;

  typedef struct packed {
    logic [TMR_W-1:0] count;
    logic expired;
  } ptd_tmr_s;

  typedef struct packed {
    logic [7:0] undervoltageConfig;
    logic [7:0] overcurrentUndervoltageDelay;
    logic [7:0] dischargeOvercurrentConfig;
    logic uvFlag;
    logic ocFlag;
    ptd_prot_e prot;
    logic uvDropsFet;
    logic [TICK_W-1:0] tickCnt;
    logic tick;
    logic discharge_fet_drive;
    logic precharge;
    logic balance;
    logic [7:0] rdData;
  } ptd_state_s;
endpackage

// ==== tb_top.sv ====
// Self-checking bench for the configuration bank
`timescale 1ns/10ps
module tb_top;
  localparam int TC = 2;
  localparam logic [4:0] FC [8] = '{5'h00, 5'h02, 5'h04, 5'h08, 5'h0A, 5'h0C, 5'h10, 5'h18};
  localparam logic [11:0] HY [4] = '{12'h0C8, 12'h190, 12'h320, 12'h4B0};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  ptd_pkg::ptd_regreq_s regReq;
  ptd_pkg::ptd_meas_s meas = '{12'hFA0, 8'h00};
  logic hostMode = 1'b0;
  logic chargerPresent = 1'b0;
  logic fastDelayScale = 1'b1;
  logic [3:0] cellCount = 4'h5;
  logic balanceRequest = 1'b0;
  logic [7:0] regRdData;
  logic dischargeFetDrive, prechargeOpenDrainOut, prechargeOpenDrainOe, balancingActive;
  logic chkReq = 1'b0;
  logic [21:0] expQ [$];
  logic [21:0] expNote;
  logic [31:0] rng = 32'h00016363;
  logic [7:0] a, d;
  int fails = 0;
  int checksDone = 0;
  int cycles = 0;
  wire [10:0] obs = {regRdData, dischargeFetDrive, prechargeOpenDrainOe, balancingActive};

  ptd_host_model ptd_host_model_i (.clk(clk), .regReq(regReq));
  ptd_config_bank #(.TickCycles(TC)) ptd_config_bank_i (.clk(clk), .arst_n(arst_n), .regReq(regReq),
    .regRdData(regRdData), .meas(meas), .hostMode(hostMode), .chargerPresent(chargerPresent),
    .fastDelayScale(fastDelayScale), .cellCount(cellCount), .balanceRequest(balanceRequest),
    .dischargeFetDrive(dischargeFetDrive), .prechargeOpenDrainOut(prechargeOpenDrainOut),
    .prechargeOpenDrainOe(prechargeOpenDrainOe), .balancingActive(balancingActive));

  initial
  begin
    forever #50 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Results sampled at the rising edge, before that edge's updates land
  always @(posedge clk)
  begin
    cycles++;
    if (chkReq)
    begin
      expNote = expQ.pop_front();
      checksDone++;
      if ((obs & expNote[21:11]) !== expNote[10:0])
      begin
        fails++;
        $display("ERROR t=%0t exp=%h got=%h", $time, expNote[10:0], obs & expNote[21:11]);
      end
      // Open-drain data must stay low; only the enable moves
      if (prechargeOpenDrainOut !== 1'b0)
      begin
        fails++;
        $display("ERROR t=%0t exp=%h got=%h", $time, 1'b0, prechargeOpenDrainOut);
      end
    end
    if (cycles == 60000)
    begin
      fails++;
      complete_run();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic note(input logic [10:0] m, input logic [10:0] v);
    expQ.push_back({m, v});
    @(negedge clk);
    chkReq = 1'b1;
    @(negedge clk);
    chkReq = 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] dv);
    ptd_host_model_i.sel(ad);
    note(11'h7F8, {dv, 3'b000});
  endtask
  task automatic outs(input logic [2:0] v);
    note(11'h007, {8'h00, v});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic setCell(input logic [11:0] c, input logic [7:0] s);
    @(negedge clk);
    meas = '{c, s};
  endtask
  // Drive must hold just before the expected expiry and be off just after
  task automatic timed(input int n);
    cyc(n - 6);
    outs(3'b100);
    cyc(10);
    outs(3'b000);
  endtask
  task automatic uvCycle(input logic [7:0] cfg);
    logic [11:0] trip, rel;
    logic [12:0] sum;
    trip = 12'h578 + 12'h064 * cfg[3:0];
    // One bit wider, so trip plus hysteresis cannot wrap before the cap
    sum = {1'b0, trip} + {1'b0, HY[cfg[5:4]]};
    rel = (sum > 13'h0CE4) ? 12'hCE4 : sum[11:0];
    ptd_host_model_i.wr(8'h07, cfg);
    setCell(trip, 8'h00);
    cyc(12);
    outs(3'b100);
    setCell(trip - 12'h001, 8'h00);
    cyc(12);
    outs(3'b000);
    rd(8'h00, 8'h01);
    setCell(rel - 12'h001, 8'h00);
    cyc(6);
    outs(3'b000);
    setCell(rel, 8'h00);
    cyc(6);
    outs(3'b100);
    ptd_host_model_i.wr(8'h00, 8'h01);
  endtask

  initial
  begin
    cyc(8);
    arst_n = 1'b1;
    rd(8'h00, 8'h00);
    rd(8'h07, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h09, 8'h00);
    outs(3'b100);
    $display("reset test done");
    for (int i = 0; i < 16; i++)
    begin
      rng = xs(rng);
      a = 8'h07 + {6'h00, rng[9:8]};
      d = rng[7:0];
      ptd_host_model_i.wr(a, d);
      rd(a, (a == 8'h0A) ? 8'h00 : (a == 8'h07) ? (d & 8'h7F) : d);
    end
    ptd_host_model_i.wr(8'h08, 8'h00);
    ptd_host_model_i.wr(8'h09, 8'h00);
    $display("register test done");
    foreach (HY[h])
      uvCycle({2'b00, h[1:0], 4'h3});
    uvCycle(8'h3F);
    $display("threshold test done");
    for (int i = 0; i < 4; i++)
    begin
      d = (i == 0) ? 8'h10 : (i == 1) ? 8'h70 : (i == 2) ? 8'h80 : 8'h00;
      fastDelayScale = (i < 3);
      cellCount = (i == 1) ? 4'hA : 4'h5;
      ptd_host_model_i.wr(8'h07, 8'h00);
      ptd_host_model_i.wr(8'h08, d);
      setCell(12'h577, 8'h00);
      if (fastDelayScale && !d[7])
        timed(FC[d[6:4]] * cellCount * TC);
      else
        timed((d[6:4] + 1) * 8000 * TC);
      setCell(12'hFA0, 8'h00);
      ptd_host_model_i.wr(8'h00, 8'h01);
    end
    $display("uv delay test done");
    hostMode = 1'b1;
    ptd_host_model_i.wr(8'h08, 8'h02);
    for (int i = 0; i < 3; i++)
    begin
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'h0F : 8'h10;
      ptd_host_model_i.wr(8'h09, d);
      setCell(12'hFA0, 8'h14);
      timed(((d < 8'h10) ? (d + 1) * 160 : (d - 15) * 800) * TC);
      rd(8'h00, 8'h02);
      setCell(12'hFA0, 8'h00);
      ptd_host_model_i.wr(8'h00, 8'h02);
      cyc(4);
      outs(3'b100);
    end
    $display("overcurrent test done");
    fastDelayScale = 1'b1;
    ptd_host_model_i.wr(8'h08, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      ptd_host_model_i.wr(8'h07, i[0] ? 8'h40 : 8'h00);
      setCell(12'h577, 8'h00);
      cyc(12);
      outs({i[0], 2'b00});
      rd(8'h00, 8'h01);
      setCell(12'hFA0, 8'h00);
      ptd_host_model_i.wr(8'h00, 8'h01);
    end
    $display("host mode test done");
    hostMode = 1'b0;
    fastDelayScale = 1'b0;
    chargerPresent = 1'b1;
    balanceRequest = 1'b1;
    ptd_host_model_i.wr(8'h07, 8'h00);
    setCell(12'h3E8, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      d = {i[1:0], 6'h00};
      ptd_host_model_i.wr(8'h09, d);
      cyc(3);
      outs({1'b1, d[6], d[7]});
    end
    hostMode = 1'b1;
    cyc(3);
    outs(3'b101);
    balanceRequest = 1'b0;
    setCell(12'hFA0, 8'h00);
    cyc(3);
    outs(3'b100);
    $display("precharge and balancing test done");
    hostMode = 1'b0;
    chargerPresent = 1'b0;
    ptd_host_model_i.wr(8'h09, 8'h00);
    setCell(12'hFA0, 8'h14);
    timed(160 * TC);
    setCell(12'hFA0, 8'h00);
    cyc(100);
    outs(3'b000);
    // Recovery takes 12.8 s, so a mid-run reset ends the trip instead
    arst_n = 1'b0;
    cyc(2);
    arst_n = 1'b1;
    rd(8'h09, 8'h00);
    outs(3'b100);
    $display("stand-alone overcurrent test done");
    complete_run();
  end
endmodule
